// [rtl/dbf_top.sv]
`timescale 1ns/1ps
module dbf_top (
  input  wire logic               clk_i,
  input  wire logic               arst_n_i,
  input  wire logic               dbg_cmd_valid_i,
  input  wire dbf_pkg::dbf_cmd_t  dbg_cmd_i,
  input  wire logic [15:0]        dbg_addr_i,
  input  wire logic [15:0]        dbg_wdata_i,
  output logic      [15:0]        dbg_rdata_o,
  output logic                    dbg_rdata_valid_o,
  input  wire logic               usr_wr_i,
  input  wire logic               usr_rd_i,
  input  wire logic [15:0]        usr_addr_i,
  input  wire logic [7:0]         usr_wdata_i,
  output logic      [7:0]         usr_rdata_o,
  output logic                    usr_rd_hit_o,
  input  wire logic               breakpoint_enable_i,
  input  wire logic               force_tag_select_i,
  input  wire logic [15:0]        cpu_addr_i,
  input  wire logic               cpu_addr_valid_i,
  input  wire logic               cpu_opcode_fetch_i,
  input  wire logic               cpu_inst_boundary_i,
  input  wire logic               cpu_tag_reached_i,
  output logic                    opcode_tag_o,
  output logic                    bgnd_req_o,
  output logic                    sys_reset_req_o
);
  import dbf_pkg::*;

  logic [15:0] bkpt_addr;
  logic [15:0] next_bkpt_addr;
  logic        rst_req;
  logic        next_rst_req;
  logic [15:0] rdata;
  logic [15:0] next_rdata;
  logic        rvalid;
  logic        next_rvalid;
  logic [7:0]  usr_rdata;
  logic [7:0]  next_usr_rdata;
  logic        usr_hit;
  logic        next_usr_hit;
  logic        dbg_fr_hit;
  logic        usr_fr_hit;

  dbf_cmp_if cmp_if ();

  // comparator takes its configuration from the status/control bits
  assign cmp_if.bkpt_addr      = bkpt_addr;
  assign cmp_if.enable         = breakpoint_enable_i;
  assign cmp_if.force_tag_select            = force_tag_select_i;
  assign cmp_if.cpu_addr       = cpu_addr_i;
  assign cmp_if.cpu_addr_valid = cpu_addr_valid_i;
  assign cmp_if.opcode_fetch   = cpu_opcode_fetch_i;
  assign cmp_if.inst_boundary  = cpu_inst_boundary_i;
  assign cmp_if.tag_reached    = cpu_tag_reached_i;

  dbf_bkpt_cmp u_cmp (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .cmp_if   (cmp_if)
  );

  always_comb begin
    dbg_fr_hit = (dbg_addr_i == FORCE_RESET_ADDR);
    usr_fr_hit = (usr_addr_i == FORCE_RESET_ADDR);

    // the user bus has no path into the breakpoint register at all
    next_bkpt_addr = bkpt_addr;
    if (dbg_cmd_valid_i && dbg_cmd_i == DBF_CMD_WRITE_BREAKPOINT_CMD) begin
      next_bkpt_addr = dbg_wdata_i;
    end

    // a pulse, not a stored bit: nothing remains to be read back
    next_rst_req = dbg_cmd_valid_i && dbg_cmd_i == DBF_CMD_WRITE_BYTE
                   && dbg_fr_hit && dbg_wdata_i[FORCE_RESET_BIT];

    next_rvalid = 1'b0;
    next_rdata  = rdata;
    if (dbg_cmd_valid_i && dbg_cmd_i == DBF_CMD_READ_BREAKPOINT_CMD) begin
      next_rvalid = 1'b1;
      next_rdata  = bkpt_addr;
    end else if (dbg_cmd_valid_i && dbg_cmd_i == DBF_CMD_READ_BYTE && dbg_fr_hit) begin
      next_rvalid = 1'b1;
      next_rdata  = {8'h00, FORCE_RESET_READ};
    end

    // user side: reads see zero, writes land nowhere
    next_usr_hit   = usr_rd_i && usr_fr_hit;
    next_usr_rdata = FORCE_RESET_READ;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bkpt_addr <= BKPT_RST;
      rst_req   <= 1'b0;
      rdata     <= BKPT_RST;
      rvalid    <= 1'b0;
      usr_rdata <= FORCE_RESET_RST;
      usr_hit   <= 1'b0;
    end else begin
      bkpt_addr <= next_bkpt_addr;
      rst_req   <= next_rst_req;
      rdata     <= next_rdata;
      rvalid    <= next_rvalid;
      usr_rdata <= next_usr_rdata;
      usr_hit   <= next_usr_hit;
    end
  end

  assign dbg_rdata_o       = rdata;
  assign dbg_rdata_valid_o = rvalid;
  assign usr_rdata_o       = usr_rdata;
  assign usr_rd_hit_o      = usr_hit;
  assign sys_reset_req_o   = rst_req;
  assign opcode_tag_o      = cmp_if.opcode_tag;
  assign bgnd_req_o        = cmp_if.bgnd_req;

  a_bkpt_write_loads: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (dbg_cmd_valid_i && dbg_cmd_i == DBF_CMD_WRITE_BREAKPOINT_CMD)
    |=> (cmp_if.bkpt_addr == $past(dbg_wdata_i)))
    else $error("breakpoint write did not load the match register");

  a_bkpt_user_blind: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !(dbg_cmd_valid_i && dbg_cmd_i == DBF_CMD_WRITE_BREAKPOINT_CMD)
    |=> $stable(cmp_if.bkpt_addr))
    else $error("breakpoint register changed without a serial write");

  a_rst_on_force_reset_bit: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (dbg_cmd_valid_i && dbg_cmd_i == DBF_CMD_WRITE_BYTE
     && dbg_addr_i == FORCE_RESET_ADDR && dbg_wdata_i[0])
    |=> sys_reset_req_o)
    else $error("force-reset write did not request a reset");

  a_no_rst_user: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (usr_wr_i && !dbg_cmd_valid_i) |=> !sys_reset_req_o)
    else $error("user write caused a reset request");

  a_rst_one_cycle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (sys_reset_req_o && !dbg_cmd_valid_i) |=> !sys_reset_req_o)
    else $error("force-reset request held state");

  a_fr_read_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (dbg_cmd_valid_i && dbg_cmd_i == DBF_CMD_READ_BYTE && dbg_addr_i == FORCE_RESET_ADDR)
    |=> (dbg_rdata_valid_o && dbg_rdata_o == 16'h0000))
    else $error("force-reset read returned nonzero");

  a_bkpt_read_back: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (dbg_cmd_valid_i && dbg_cmd_i == DBF_CMD_READ_BREAKPOINT_CMD)
    |=> (dbg_rdata_valid_o && dbg_rdata_o == $past(cmp_if.bkpt_addr)))
    else $error("breakpoint read returned wrong value");

  a_user_read_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (usr_rd_i && usr_addr_i == FORCE_RESET_ADDR)
    |=> (usr_rd_hit_o && usr_rdata_o == 8'h00))
    else $error("user read of force-reset register not zero");

  // every answer pulse must trace back to the command that asked for it
  a_rvalid_cause: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    dbg_rdata_valid_o |-> ($past(dbg_cmd_valid_i)
      && ($past(dbg_cmd_i) == DBF_CMD_READ_BREAKPOINT_CMD
          || ($past(dbg_cmd_i) == DBF_CMD_READ_BYTE
              && $past(dbg_addr_i) == FORCE_RESET_ADDR))))
    else $error("read data valid without a matching read command");

  a_rdata_holds: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !dbg_rdata_valid_o |-> $stable(dbg_rdata_o))
    else $error("read data changed without a read");

  a_rvalid_pulse: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (dbg_rdata_valid_o && !dbg_cmd_valid_i) |=> !dbg_rdata_valid_o)
    else $error("read data valid held longer than one cycle");

  a_rreq_cause: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    sys_reset_req_o |-> ($past(dbg_cmd_valid_i) && $past(dbg_cmd_i) == DBF_CMD_WRITE_BYTE
      && $past(dbg_addr_i) == FORCE_RESET_ADDR && $past(dbg_wdata_i[FORCE_RESET_BIT])))
    else $error("reset request without a force-reset write");

  a_rst_bit_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (dbg_cmd_valid_i && dbg_cmd_i == DBF_CMD_WRITE_BYTE
     && dbg_addr_i == FORCE_RESET_ADDR && !dbg_wdata_i[FORCE_RESET_BIT])
    |=> !sys_reset_req_o)
    else $error("force-reset write of zero requested a reset");

  // a user write must neither reset nor reach the breakpoint register
  a_user_write_inert: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (usr_wr_i && usr_addr_i == FORCE_RESET_ADDR && usr_wdata_i[FORCE_RESET_BIT]
     && !dbg_cmd_valid_i) |=> (!sys_reset_req_o && $stable(cmp_if.bkpt_addr)))
    else $error("user write to force-reset register took effect");

  a_user_hit_cause: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    usr_rd_hit_o |-> ($past(usr_rd_i) && $past(usr_addr_i) == FORCE_RESET_ADDR))
    else $error("user read hit without a read of the force-reset address");

  a_user_data_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    usr_rdata_o == 8'h00)
    else $error("user read data not zero");

  a_byte_miss_quiet: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (dbg_cmd_valid_i && dbg_cmd_i == DBF_CMD_READ_BYTE && dbg_addr_i != FORCE_RESET_ADDR)
    |=> !dbg_rdata_valid_o)
    else $error("byte read of another address answered");

  a_bkpt_byte_blind: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (dbg_cmd_valid_i && dbg_cmd_i == DBF_CMD_WRITE_BYTE) |=> $stable(cmp_if.bkpt_addr))
    else $error("byte write reached the breakpoint register");

  a_tag_cfg_bits: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    opcode_tag_o |-> (breakpoint_enable_i && !force_tag_select_i && cpu_opcode_fetch_i))
    else $error("opcode tag against the configuration bits");

  a_bgnd_needs_en: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    bgnd_req_o |-> $past(breakpoint_enable_i))
    else $error("background request from a disabled breakpoint");
endmodule

// [rtl/dbf_pkg.sv]
package dbf_pkg;

  localparam int          ADDR_W           = 16;
  localparam int          BYTE_W           = 8;

  // serial debug command codes as seen by this block
  typedef enum logic [1:0] {
    DBF_CMD_READ_BYTE  = 2'h0,
    DBF_CMD_WRITE_BYTE = 2'h1,
    DBF_CMD_READ_BREAKPOINT_CMD  = 2'h2,
    DBF_CMD_WRITE_BREAKPOINT_CMD = 2'h3
  } dbf_cmd_t;

  // breakpoint comparator state
  typedef enum logic [0:0] {
    DBF_IDLE       = 1'h0,
    DBF_FORCE_PEND = 1'h1
  } dbf_state_t;

  localparam logic [15:0] FORCE_RESET_ADDR = 16'h1800;
  localparam int          FORCE_RESET_BIT  = 0;
  localparam logic [7:0]  FORCE_RESET_READ = 8'h00;
  localparam logic [7:0]  FORCE_RESET_RST  = 8'h00;
  localparam logic [15:0] BKPT_RST         = 16'h0000;

endpackage

// [rtl/dbf_cmp_if.sv]
`timescale 1ns/1ps
interface dbf_cmp_if;
  logic [15:0] bkpt_addr;
  logic        enable;
  logic        force_tag_select;
  logic [15:0] cpu_addr;
  logic        cpu_addr_valid;
  logic        opcode_fetch;
  logic        inst_boundary;
  logic        tag_reached;
  logic        bgnd_req;
  logic        opcode_tag;

  modport top (
    output bkpt_addr, enable, force_tag_select, cpu_addr, cpu_addr_valid,
    output opcode_fetch, inst_boundary, tag_reached,
    input  bgnd_req, opcode_tag
  );

  modport cmp (
    input  bkpt_addr, enable, force_tag_select, cpu_addr, cpu_addr_valid,
    input  opcode_fetch, inst_boundary, tag_reached,
    output bgnd_req, opcode_tag
  );
endinterface

// [rtl/dbf_bkpt_cmp.sv]
`timescale 1ns/1ps
module dbf_bkpt_cmp (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  dbf_cmp_if.cmp    cmp_if
);
  import dbf_pkg::*;

  dbf_state_t state;
  dbf_state_t next_state;
  logic       bgnd_req;
  logic       next_bgnd_req;
  logic       addr_match;
  logic       force_match;
  logic       take;

  always_comb begin
    addr_match    = cmp_if.enable && cmp_if.cpu_addr_valid
                    && (cmp_if.cpu_addr == cmp_if.bkpt_addr);
    force_match   = addr_match && cmp_if.force_tag_select;
    take          = cmp_if.enable && cmp_if.inst_boundary
                    && (state == DBF_FORCE_PEND || force_match);
    next_state    = state;
    // disabling drops a pending force so a stale match never fires
    if (!cmp_if.enable || take) begin
      next_state = DBF_IDLE;
    end else if (force_match) begin
      next_state = DBF_FORCE_PEND;
    end
    next_bgnd_req = take || (cmp_if.enable && cmp_if.tag_reached);
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state    <= DBF_IDLE;
      bgnd_req <= 1'b0;
    end else begin
      state    <= next_state;
      bgnd_req <= next_bgnd_req;
    end
  end

  // tag rides along with the fetch, so it cannot wait a cycle
  assign cmp_if.opcode_tag = addr_match && !cmp_if.force_tag_select && cmp_if.opcode_fetch;
  assign cmp_if.bgnd_req   = bgnd_req;

  a_force_at_boundary: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (cmp_if.enable && cmp_if.force_tag_select && cmp_if.cpu_addr_valid
     && cmp_if.cpu_addr == cmp_if.bkpt_addr && cmp_if.inst_boundary)
    |=> cmp_if.bgnd_req)
    else $error("forced breakpoint missed the instruction boundary");

  a_tag_on_match: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    cmp_if.opcode_tag |-> (cmp_if.enable && !cmp_if.force_tag_select && cmp_if.opcode_fetch
                           && cmp_if.cpu_addr == cmp_if.bkpt_addr))
    else $error("opcode tagged without a tag-mode match");

  a_disabled_quiet: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (!cmp_if.enable && !$past(cmp_if.enable)) |-> (!cmp_if.bgnd_req && !cmp_if.opcode_tag))
    else $error("breakpoint acted while disabled");

  a_tag_exec_bgnd: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (cmp_if.enable && cmp_if.tag_reached) |=> cmp_if.bgnd_req)
    else $error("tagged opcode reached execution without background request");
endmodule

// [bench/dbf_host_model.sv]
`timescale 1ns/1ps
module dbf_host_model
  import dbf_pkg::*;
(
  input  wire logic              clk_i,
  output logic                   valid_o,
  output dbf_pkg::dbf_cmd_t      cmd_o,
  output logic            [15:0] addr_o,
  output logic            [15:0] wdata_o,
  input  wire logic       [15:0] rdata_i,
  input  wire logic              rvalid_i
);
  import dbf_pkg::*;
  initial begin
    valid_o = 1'b0;
    cmd_o   = DBF_CMD_READ_BYTE;
    addr_o  = 16'h0000;
    wdata_o = 16'h0000;
  end
  // breakpoint and force reset reached only by serial commands
  task automatic xfer(input dbf_cmd_t c, input logic [15:0] a, d,
                      output logic [15:0] rd, output logic rv);
    @(negedge clk_i);
    valid_o = 1'b1;
    cmd_o   = c;
    addr_o  = a;
    wdata_o = d;
    @(negedge clk_i);
    valid_o = 1'b0;
    // released address and data lines must not keep the last value
    addr_o  = ~a;
    wdata_o = ~d;
    rd      = rdata_i;
    rv      = rvalid_i;
  endtask
endmodule

// [bench/dbf_top_tb_top.sv]
`timescale 1ns/1ps
module dbf_top_tb_top;
  import dbf_pkg::*;
  logic              clk_i, arst_n_i, dbg_cmd_valid_i, dbg_rdata_valid_o;
  logic              usr_wr_i, usr_rd_i, usr_rd_hit_o, opcode_tag_o;
  logic              breakpoint_enable_i, force_tag_select_i, cpu_addr_valid_i;
  logic              cpu_opcode_fetch_i, cpu_inst_boundary_i, cpu_tag_reached_i;
  logic              bgnd_req_o, sys_reset_req_o, rv;
  logic       [15:0] dbg_addr_i, dbg_wdata_i, dbg_rdata_o, usr_addr_i, cpu_addr_i, rd;
  logic        [7:0] usr_wdata_i, usr_rdata_o;
  dbf_cmd_t          dbg_cmd_i;
  int                fail_count, checks, cycles;

  dbf_top uut (.clk_i, .arst_n_i, .dbg_cmd_valid_i, .dbg_cmd_i, .dbg_addr_i, .dbg_wdata_i,
    .dbg_rdata_o, .dbg_rdata_valid_o, .usr_wr_i, .usr_rd_i, .usr_addr_i, .usr_wdata_i,
    .usr_rdata_o, .usr_rd_hit_o, .breakpoint_enable_i, .force_tag_select_i, .cpu_addr_i,
    .cpu_addr_valid_i, .cpu_opcode_fetch_i, .cpu_inst_boundary_i, .cpu_tag_reached_i,
    .opcode_tag_o, .bgnd_req_o, .sys_reset_req_o);
  dbf_host_model host (.clk_i, .valid_o(dbg_cmd_valid_i), .cmd_o(dbg_cmd_i),
    .addr_o(dbg_addr_i), .wdata_o(dbg_wdata_i), .rdata_i(dbg_rdata_o),
    .rvalid_i(dbg_rdata_valid_o));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [15:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d, fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic do_reset();
    @(negedge clk_i);
    arst_n_i = 1'b0;
    repeat (3) @(negedge clk_i);
    arst_n_i = 1'b1;
  endtask

  // f = {enable, select, addr valid, fetch, boundary, tag reached}
  task automatic cpu(input logic [5:0] f, input logic [15:0] a);
    @(negedge clk_i);
    {breakpoint_enable_i, force_tag_select_i, cpu_addr_valid_i} = f[5:3];
    {cpu_opcode_fetch_i, cpu_inst_boundary_i, cpu_tag_reached_i} = f[2:0];
    cpu_addr_i = a;
    #1;
  endtask

  task automatic usr(input logic w, r, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {usr_wr_i, usr_rd_i, usr_addr_i, usr_wdata_i} = {w, r, a, d};
    @(negedge clk_i);
    {usr_wr_i, usr_rd_i, usr_addr_i, usr_wdata_i} = {1'b0, 1'b0, ~a, ~d};
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      test_done();
    end
  end

  initial begin
    {usr_wr_i, usr_rd_i, usr_addr_i, usr_wdata_i, arst_n_i} = '0;
    cpu(6'b000000, 16'h0000);
    do_reset();
    for (int i = 0; i < 2; i++) begin
      host.xfer(DBF_CMD_WRITE_BREAKPOINT_CMD, 16'h0000, i ? 16'h1234 : 16'hFFFF, rd, rv);
      host.xfer(DBF_CMD_READ_BREAKPOINT_CMD, 16'h0000, 16'h0000, rd, rv);
      chk(rd, i ? 16'h1234 : 16'hFFFF, "bkpt read");
      chk({15'h0, rv}, 16'h0001, "bkpt valid");
    end
    $display("test breakpoint register done");
    cpu(6'b111000, 16'h1234);
    cpu(6'b110000, 16'h0000);
    chk({15'h0, bgnd_req_o}, 16'h0000, "force early");
    cpu(6'b110010, 16'h0000);
    cpu(6'b110000, 16'h0000);
    chk({15'h0, bgnd_req_o}, 16'h0001, "force taken");
    cpu(6'b110010, 16'h0000);
    cpu(6'b101100, 16'h1234);
    chk({15'h0, bgnd_req_o}, 16'h0000, "force once");
    chk({15'h0, opcode_tag_o}, 16'h0001, "tag match");
    cpu(6'b101100, 16'h1235);
    chk({15'h0, opcode_tag_o}, 16'h0000, "tag miss");
    cpu(6'b100001, 16'h0000);
    cpu(6'b100000, 16'h0000);
    chk({15'h0, bgnd_req_o}, 16'h0001, "tag reached");
    cpu(6'b011100, 16'h1234);
    chk({15'h0, opcode_tag_o}, 16'h0000, "tag disabled");
    cpu(6'b111000, 16'h1234);
    cpu(6'b010000, 16'h0000);
    cpu(6'b110010, 16'h0000);
    cpu(6'b000000, 16'h0000);
    chk({15'h0, bgnd_req_o}, 16'h0000, "pending dropped");
    $display("test breakpoint logic done");
    usr(1'b1, 1'b0, FORCE_RESET_ADDR, 8'hFF);
    chk({15'h0, sys_reset_req_o}, 16'h0000, "user write");
    usr(1'b0, 1'b1, FORCE_RESET_ADDR, 8'h00);
    chk({usr_rdata_o, 7'h0, usr_rd_hit_o}, 16'h0001, "user read");
    host.xfer(DBF_CMD_WRITE_BYTE, FORCE_RESET_ADDR, 16'h00FE, rd, rv);
    chk({15'h0, sys_reset_req_o}, 16'h0000, "bit0 clear");
    host.xfer(DBF_CMD_WRITE_BYTE, 16'h1801, 16'h0001, rd, rv);
    chk({15'h0, sys_reset_req_o}, 16'h0000, "other addr");
    host.xfer(DBF_CMD_READ_BYTE, 16'h1801, 16'h0000, rd, rv);
    chk({15'h0, rv}, 16'h0000, "other read");
    host.xfer(DBF_CMD_READ_BYTE, FORCE_RESET_ADDR, 16'h0000, rd, rv);
    chk({rd[7:0], 7'h0, rv}, 16'h0001, "debug read");
    host.xfer(DBF_CMD_READ_BREAKPOINT_CMD, 16'h0000, 16'h0000, rd, rv);
    chk(rd, 16'h1234, "bkpt kept");
    host.xfer(DBF_CMD_WRITE_BYTE, FORCE_RESET_ADDR, 16'h0001, rd, rv);
    chk({15'h0, sys_reset_req_o}, 16'h0001, "force reset");
    @(negedge clk_i);
    chk({15'h0, sys_reset_req_o}, 16'h0000, "no state");
    do_reset();
    host.xfer(DBF_CMD_READ_BREAKPOINT_CMD, 16'h0000, 16'h0000, rd, rv);
    chk(rd, BKPT_RST, "bkpt after reset");
    $display("test force reset done");
    test_done();
  end
endmodule
